// [rtl/gsl_pkg.sv]
// Package for the global support, performance monitor and loopback block.
// Assumes a single 100 MHz core clock and a plain register port.
`default_nettype none
package gsl_pkg;
   localparam int          REF_DIVIDE       = 8000;
   localparam int          HALF_DIVIDE      = REF_DIVIDE / 2;
   localparam int          PIN_COUNT        = 8;
   localparam int          CNT_W            = 24;
   localparam int          ADDR_W           = 4;
   localparam logic [3:0]  ADDR_GLOBAL_CTRL = 4'h0;
   localparam logic [3:0]  ADDR_PIN_CTRL    = 4'h1;
   localparam logic [3:0]  ADDR_PORT_CTRL   = 4'h2;
   localparam logic [3:0]  ADDR_STATUS      = 4'h3;
   localparam logic [3:0]  ADDR_HOLD        = 4'h4;
   localparam logic [3:0]  ADDR_PIN_IN      = 4'h5;
   // Global control field positions.
   localparam int          GC_UPD_SRC       = 0;
   localparam int          GC_OUT8K_EN      = 2;
   localparam int          GC_IN8K_SEL      = 3;
   localparam int          GC_ERR_SRC       = 4;
   localparam int          GC_ERR_BIT       = 5;
   localparam int          GC_UPD_BIT       = 6;
   localparam int          GC_IRQ_EN        = 7;
   // Port control field positions.
   localparam int          PC_LOOP_MODE     = 0;
   localparam int          PC_LOOP_TIMED    = 3;
   localparam int          PC_ALARM_A       = 4;
   localparam int          PC_ALARM_B       = 8;
   localparam int          PC_ERR_BIT       = 12;
   localparam int          PC_UPD_BIT       = 13;
   localparam int          PC_USE_GLOBAL    = 14;
   localparam int          PC_POWER_DOWN    = 15;
   localparam int          PC_PORT_RESET    = 16;
   localparam int          PC_XCVR_EN       = 17;
   localparam int          PC_BLOCK_ERR     = 18;
   localparam logic [31:0] GLOBAL_RESET     = 32'h0;
   localparam logic [31:0] PIN_RESET        = 32'h0;
   localparam logic [31:0] PORT_RESET       = 32'h0001_8000;
   localparam logic [1:0]  MODE_INPUT       = 2'h0;
   localparam logic [1:0]  MODE_ALARM       = 2'h1;
   localparam logic [1:0]  MODE_DRIVE0      = 2'h2;
   localparam logic [1:0]  MODE_DRIVE1      = 2'h3;
endpackage : gsl_pkg
`default_nettype wire

// [rtl/gsl_top.sv]
// Global support: one-second reference, general-purpose pins, monitor
// update-clear, error insertion source and loopback decode.
// Assumes all inputs synchronous to ref_clk_i; ref_8k_i is the 8 kHz level.
//
// Summary of operation
// - Divide the 8 kHz reference by 8000 into a half-duty one-second signal.
// - One-second rising edge sets a latched flag; interrupt only when enabled.
// - Update source 1X makes every one-second rising edge an update-clear.
// - Eight pins, each input, output, global signal or alarm output.
// - Port down or in reset, mode 01 pins drive low.
// - Pin-sourced 8k, error and update inputs are low unless selected.
// - Pin 2 outputs 8k, pin 4 inputs 8k, pin 6 error, pin 8 update.
// - Mode field: 00 input, 01 alarm, 10 drive 0, 11 drive 1.
// - Alarm select codes choose single alarms or fixed combinations.
// - Counter holds over one second of events and saturates.
// - Nonzero status bit plus latched bit on zero to one.
// - Every counted event sets a latched event bit.
// - Update-clear copies count to holding register and clears counter.
// - Event during clear loads the counter with one.
// - Update from one-second, pin, port bit or global bit.
// - Update status follows hardware request high and low.
// - Port not on global update is masked from global status.
// - Error source: own bits when select 1, else global, port or pin 6.
// - Loopback mode decodes to analog, line, payload, diagnostic sets.
// - Loop-timed mode suppresses analog loopback.
// - Analog loop returns line outputs, or digital clock and data.
`default_nettype none
module gsl_top
   import gsl_pkg::*;
(
   input  wire logic                      ref_clk_i,
   input  wire logic                      reset_n_i,
   input  wire logic [gsl_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]               wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [31:0]               rdata_o,
   input  wire logic                      ref_8k_i,
   input  wire logic [7:0]                pin_i,
   output logic      [7:0]                pin_o,
   output logic      [7:0]                pin_oe_n_o,
   input  wire logic [5:0]                alarm_i,
   input  wire logic                      count_event_i,
   input  wire logic                      block_err_bit_i,
   output logic                           global_ref_8k_o,
   output logic                           irq_o,
   output logic                           error_insert_o,
   output logic                           update_clear_o,
   output logic                           analog_loop_o,
   output logic                           line_loop_o,
   output logic                           payload_loop_o,
   output logic                           diagnostic_loop_o,
   input  wire logic                      line_tx_positive_i,
   input  wire logic                      line_tx_negative_i,
   input  wire logic                      tx_line_clock_i,
   input  wire logic                      tx_line_pos_data_i,
   input  wire logic                      tx_line_neg_data_i,
   input  wire logic                      line_rx_positive_i,
   input  wire logic                      line_rx_negative_i,
   input  wire logic                      rx_line_clock_in_i,
   input  wire logic                      rx_line_pos_data_i,
   input  wire logic                      rx_line_neg_data_i,
   output logic                           rx_sel_pos_o,
   output logic                           rx_sel_neg_o,
   output logic                           rx_sel_clock_o
);
   import gsl_pkg::*;

   typedef enum logic [2:0] {
      UPD_IDLE = 3'b001,
      UPD_BUSY = 3'b010,
      UPD_DONE = 3'b100
   } gsl_upd_t;

   typedef struct packed {
      logic [31:0]      gctrl;
      logic [31:0]      pctrl;
      logic [15:0]      pin_mode;
      logic [12:0]      div_cnt;
      logic             sec;
      logic             sec_prev;
      logic             ref_prev;
      logic             sec_flag;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] hold;
      logic             nonzero_flag;
      logic             event_flag;
      logic             upd_status;
      logic             req_prev;
      gsl_upd_t         upd;
      logic [31:0]      rdata;
      logic [7:0]       pin_out;
      logic [7:0]       pin_oe_n;
      logic             irq;
      logic             err_ins;
      logic             upd_clear;
      logic [3:0]       loops;
      logic [2:0]       rx_sel;
   } gsl_state_t;

   gsl_state_t s_q;
   gsl_state_t s_d;

   logic       ref_sel;
   logic       ref_rise;
   logic       sec_rise;
   logic       hw_req;
   logic       sw_req;
   logic       req;
   logic       clear_now;
   logic [2:0] lbm;
   logic       port_idle;
   logic [5:0] alarm_mask_a;
   logic [5:0] alarm_mask_b;

   function automatic logic [5:0] gsl_alarm_mask(input logic [3:0] code);
      logic [5:0] m;
      m = 6'h00;
      unique case (code)
         4'h0:    m = 6'h01;
         4'h1:    m = 6'h02;
         4'h2:    m = 6'h04;
         4'h3:    m = 6'h08;
         4'h4:    m = 6'h10;
         4'h5:    m = 6'h20;
         4'hb:    m = 6'h0d;
         4'hd:    m = 6'h0d;
         4'he:    m = 6'h30;
         4'hf:    m = 6'h3f;
         default: m = 6'h00;
      endcase
      return m;
   endfunction : gsl_alarm_mask

   always_comb begin
      // Pin 4 carries the 8k reference only when selected; otherwise the
      // core sees the internal source.
      ref_sel   = s_q.gctrl[GC_IN8K_SEL] ? pin_i[3] : ref_8k_i;
      ref_rise  = ref_sel & ~s_q.ref_prev;
      sec_rise  = s_q.sec & ~s_q.sec_prev;
      // The one-second level is the request, so status can follow it high and low.
      hw_req    = s_q.gctrl[GC_UPD_SRC+1] ? s_q.sec
                : (s_q.gctrl[GC_UPD_SRC] & pin_i[7]);
      sw_req    = s_q.pctrl[PC_USE_GLOBAL] ? s_q.gctrl[GC_UPD_BIT]
                : s_q.pctrl[PC_UPD_BIT];
      req       = s_q.gctrl[GC_UPD_SRC+1] | s_q.gctrl[GC_UPD_SRC] ? hw_req : sw_req;
      clear_now = req & ~s_q.req_prev;
      lbm       = s_q.pctrl[PC_LOOP_MODE +: 3];
      port_idle = s_q.pctrl[PC_POWER_DOWN] | s_q.pctrl[PC_PORT_RESET];
      alarm_mask_a = gsl_alarm_mask(s_q.pctrl[PC_ALARM_A +: 4]);
      alarm_mask_b = gsl_alarm_mask(s_q.pctrl[PC_ALARM_B +: 4]);
   end

   always_comb begin
      s_d           = s_q;
      s_d.ref_prev  = ref_sel;
      s_d.sec_prev  = s_q.sec;
      s_d.req_prev  = req;
      s_d.rdata     = 32'h0;
      s_d.upd_clear = clear_now;

      if (ref_rise) begin
         if (s_q.div_cnt == 13'(HALF_DIVIDE - 1)) begin
            s_d.div_cnt = 13'h0;
            s_d.sec     = ~s_q.sec;
         end else begin
            s_d.div_cnt = s_q.div_cnt + 13'h1;
         end
      end
      if (sec_rise) begin
         s_d.sec_flag = 1'b1;
      end

      if (count_event_i) begin
         s_d.event_flag = 1'b1;
         if (s_q.count == '0) begin
            s_d.nonzero_flag = 1'b1;
         end
      end
      if (clear_now) begin
         s_d.hold  = s_q.count;
         s_d.count = count_event_i ? CNT_W'(1) : '0;
      end else if (count_event_i && s_q.count != '1) begin
         s_d.count = s_q.count + CNT_W'(1);
      end

      // Status rises after the request and falls after it drops.
      unique case (s_q.upd)
         UPD_IDLE: if (req) s_d.upd = UPD_BUSY;
         UPD_BUSY: s_d.upd = UPD_DONE;
         UPD_DONE: if (!req) s_d.upd = UPD_IDLE;
         default:  s_d.upd = UPD_IDLE;
      endcase
      s_d.upd_status = (s_q.upd == UPD_DONE) & req;

      if (wr_i) begin
         unique case (addr_i)
            ADDR_GLOBAL_CTRL: s_d.gctrl    = wdata_i;
            ADDR_PIN_CTRL:    s_d.pin_mode = wdata_i[15:0];
            ADDR_PORT_CTRL:   s_d.pctrl    = wdata_i;
            ADDR_STATUS: begin
               // Write one to clear; a new event in the same cycle wins.
               if (wdata_i[0] && !sec_rise) s_d.sec_flag = 1'b0;
               if (wdata_i[1] && !count_event_i) s_d.event_flag = 1'b0;
               if (wdata_i[2] && !(count_event_i && s_q.count == '0)) begin
                  s_d.nonzero_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            ADDR_GLOBAL_CTRL: s_d.rdata = s_q.gctrl;
            ADDR_PIN_CTRL:    s_d.rdata = {16'h0, s_q.pin_mode};
            ADDR_PORT_CTRL:   s_d.rdata = s_q.pctrl;
            ADDR_STATUS:      s_d.rdata = {26'h0, s_q.count != '0,
                                 s_q.upd_status & s_q.pctrl[PC_USE_GLOBAL],
                                 s_q.upd_status, s_q.nonzero_flag,
                                 s_q.event_flag, s_q.sec_flag};
            ADDR_HOLD:        s_d.rdata = {8'h0, s_q.hold};
            ADDR_PIN_IN:      s_d.rdata = {24'h0, pin_i};
            default:          s_d.rdata = 32'h0;
         endcase
      end

      s_d.irq = s_q.sec_flag & s_q.gctrl[GC_IRQ_EN];

      for (int i = 0; i < PIN_COUNT; i++) begin
         logic [1:0] m;
         m = s_q.pin_mode[2*i +: 2];
         s_d.pin_oe_n[i] = 1'b1;
         s_d.pin_out[i]  = 1'b0;
         unique case (m)
            MODE_INPUT:  s_d.pin_oe_n[i] = 1'b1;
            MODE_ALARM: begin
               s_d.pin_oe_n[i] = 1'b0;
               s_d.pin_out[i]  = port_idle ? 1'b0
                  : |(alarm_i & (i[0] ? alarm_mask_b : alarm_mask_a));
            end
            MODE_DRIVE0: s_d.pin_oe_n[i] = 1'b0;
            MODE_DRIVE1: begin
               s_d.pin_oe_n[i] = 1'b0;
               s_d.pin_out[i]  = 1'b1;
            end
         endcase
      end
      if (s_q.gctrl[GC_OUT8K_EN]) begin
         s_d.pin_oe_n[1] = 1'b0;
         s_d.pin_out[1]  = ref_sel;
      end
      if (s_q.gctrl[GC_IN8K_SEL]) s_d.pin_oe_n[3] = 1'b1;
      if (s_q.gctrl[GC_ERR_SRC]) s_d.pin_oe_n[5] = 1'b1;
      if (s_q.gctrl[GC_UPD_SRC +: 2] == 2'h1) s_d.pin_oe_n[7] = 1'b1;

      s_d.err_ins = s_q.pctrl[PC_BLOCK_ERR] ? block_err_bit_i
         : (s_q.gctrl[GC_ERR_BIT] | s_q.pctrl[PC_ERR_BIT]
            | (s_q.gctrl[GC_ERR_SRC] & pin_i[5]));

      unique case (lbm)
         3'b000:  s_d.loops = 4'b0000;
         3'b001:  s_d.loops = {~s_q.pctrl[PC_LOOP_TIMED], 3'b000};
         3'b010:  s_d.loops = 4'b0100;
         3'b011:  s_d.loops = 4'b0010;
         3'b110:  s_d.loops = 4'b0101;
         default: s_d.loops = 4'b0001;
      endcase
      if (s_d.loops[3]) begin
         s_d.rx_sel = s_q.pctrl[PC_XCVR_EN]
            ? {1'b0, line_tx_positive_i, line_tx_negative_i}
            : {tx_line_clock_i, tx_line_pos_data_i, tx_line_neg_data_i};
      end else begin
         s_d.rx_sel = s_q.pctrl[PC_XCVR_EN]
            ? {1'b0, line_rx_positive_i, line_rx_negative_i}
            : {rx_line_clock_in_i, rx_line_pos_data_i, rx_line_neg_data_i};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s_q          <= '0;
         s_q.gctrl    <= GLOBAL_RESET;
         s_q.pctrl    <= PORT_RESET;
         s_q.pin_mode <= PIN_RESET[15:0];
         s_q.pin_oe_n <= 8'hff;
         s_q.upd      <= UPD_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o           = s_q.rdata;
   assign pin_o             = s_q.pin_out;
   assign pin_oe_n_o        = s_q.pin_oe_n;
   assign global_ref_8k_o   = s_q.ref_prev;
   assign irq_o             = s_q.irq;
   assign error_insert_o    = s_q.err_ins;
   assign update_clear_o    = s_q.upd_clear;
   assign analog_loop_o     = s_q.loops[3];
   assign line_loop_o       = s_q.loops[2];
   assign payload_loop_o    = s_q.loops[1];
   assign diagnostic_loop_o = s_q.loops[0];
   assign rx_sel_clock_o    = s_q.rx_sel[2];
   assign rx_sel_pos_o      = s_q.rx_sel[1];
   assign rx_sel_neg_o      = s_q.rx_sel[0];

   // The counter never wraps from full to zero.
   a_count_saturates: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (s_q.count == '1 && !clear_now) |=> s_q.count == '1)
      else $error("counter wrapped");
   a_clear_loads_one: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clear_now && count_event_i) |=> s_q.count == CNT_W'(1))
      else $error("event lost at clear");
   a_hold_copies: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clear_now |=> s_q.hold == $past(s_q.count))
      else $error("holding register not loaded");
   a_sec_flag_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      sec_rise |=> s_q.sec_flag ##1 (irq_o == s_q.gctrl[GC_IRQ_EN] || $past(wr_i)))
      else $error("second flag not set");
   a_event_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      count_event_i |=> s_q.event_flag)
      else $error("event flag missed");
   a_alb_timed: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.pctrl[PC_LOOP_TIMED] |=> !analog_loop_o)
      else $error("analog loop in loop timed mode");
   a_idle_alarm_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (port_idle && s_q.pin_mode[1:0] == MODE_ALARM && !s_q.gctrl[GC_OUT8K_EN])
      |=> (!pin_o[0] && !pin_oe_n_o[0]))
      else $error("idle alarm pin not low");
   sequence s_req_fresh;
      req && s_q.upd == UPD_IDLE;
   endsequence
   sequence s_req_held;
      req[*2];
   endsequence
   a_status_follows: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_req_fresh ##1 s_req_held |=> s_q.upd_status)
      else $error("update status late");
   a_status_drops: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !req |=> !s_q.upd_status)
      else $error("update status stuck");
   a_clear_single: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      update_clear_o |=> !update_clear_o)
      else $error("update clear repeated");
   a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !s_q.gctrl[GC_IRQ_EN] |=> !irq_o)
      else $error("masked interrupt raised");
   a_sec_steady: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !(ref_rise && s_q.div_cnt == 13'(HALF_DIVIDE - 1)) |=> $stable(s_q.sec))
      else $error("second reference toggled early");
   a_div_range: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.div_cnt < 13'(HALF_DIVIDE))
      else $error("divider out of range");
   a_ref_out_pin: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.gctrl[GC_OUT8K_EN] |=> (!pin_oe_n_o[1] && pin_o[1] == global_ref_8k_o))
      else $error("reference not on pin 2");
   a_ref_in_pin: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.gctrl[GC_IN8K_SEL] |=> pin_oe_n_o[3])
      else $error("reference input pin driven");
   a_err_pin_ignored: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (!s_q.gctrl[GC_ERR_SRC] && !s_q.gctrl[GC_ERR_BIT] && !s_q.pctrl[PC_ERR_BIT]
         && !s_q.pctrl[PC_BLOCK_ERR]) |=> !error_insert_o)
      else $error("error insertion without source");
   a_diag_upper: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      lbm[2] |=> (diagnostic_loop_o && !analog_loop_o && !payload_loop_o))
      else $error("diagnostic loop not decoded");
   a_no_loop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      lbm == 3'b000 |=> !(analog_loop_o || line_loop_o || payload_loop_o || diagnostic_loop_o))
      else $error("loop active in mode 000");
   a_drive_one: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (s_q.pin_mode[15:14] == MODE_DRIVE1 && s_q.gctrl[GC_UPD_SRC +: 2] != 2'h1)
         |=> (pin_o[7] && !pin_oe_n_o[7]))
      else $error("pin 8 not driven high");
   a_input_mode: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      s_q.pin_mode[1:0] == MODE_INPUT |=> pin_oe_n_o[0])
      else $error("input pin driven");
endmodule : gsl_top
`default_nettype wire

// [verification/gsl_top_tb.sv]
// Self-checking bench for the global support block: pins, 8 kHz routing,
// error insertion source, loopback decode and monitor update-clear.
// Assumes the register map, field positions and latencies of gsl_pkg.
`default_nettype none
module gsl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gsl_pkg::*;
   localparam logic [31:0] G_T [6] = '{32'h0, 32'h1 << GC_ERR_BIT, 32'h0,
                                       32'h1 << GC_ERR_SRC, 32'h1 << GC_ERR_BIT, 32'h0};
   localparam logic [31:0] P_T [6] = '{32'h0, 32'h0, 32'h1 << PC_ERR_BIT, 32'h0,
                                       32'h1 << PC_BLOCK_ERR, 32'h1 << PC_BLOCK_ERR};
   logic        ref_clk_i    = 1'b0;
   logic        reset_n_i    = 1'b0;
   logic        wr_i         = 1'b0;
   logic        rd_i         = 1'b0;
   logic        ref_8k       = 1'b0;
   logic        ref_lvl      = 1'b0;
   logic        ev           = 1'b0;
   logic        blk          = 1'b0;
   logic        tog          = 1'b0;
   logic        pend         = 1'b0;
   logic        ev_last      = 1'b0;
   logic [3:0]  addr         = 4'h0;
   logic [31:0] wdata        = 32'h0;
   logic [7:0]  pin_i        = 8'h0;
   logic [5:0]  alarm        = 6'h0;
   logic [9:0]  lin          = 10'h0;
   logic [31:0] rnd          = 32'hb077;
   logic [31:0] rdata;
   logic [7:0]  pin_o;
   logic [7:0]  oe_n;
   logic [3:0]  lb;
   logic [2:0]  rx;
   logic        ref_o, irq, err, uc;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          fails        = 0;
   int          total_checks = 0;
   int          cnt_m        = 0;
   int          hold_exp     = 0;
   int          n            = 0;

   gsl_top gsl_top_inst (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ref_8k_i(ref_8k), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_n_o(oe_n), .alarm_i(alarm), .count_event_i(ev),
      .block_err_bit_i(blk), .global_ref_8k_o(ref_o), .irq_o(irq), .error_insert_o(err),
      .update_clear_o(uc), .analog_loop_o(lb[3]), .line_loop_o(lb[2]),
      .payload_loop_o(lb[1]), .diagnostic_loop_o(lb[0]),
      .line_tx_positive_i(lin[0]), .line_tx_negative_i(lin[1]), .tx_line_clock_i(lin[2]),
      .tx_line_pos_data_i(lin[3]), .tx_line_neg_data_i(lin[4]), .line_rx_positive_i(lin[5]),
      .line_rx_negative_i(lin[6]), .rx_line_clock_in_i(lin[7]), .rx_line_pos_data_i(lin[8]),
      .rx_line_neg_data_i(lin[9]), .rx_sel_pos_o(rx[2]), .rx_sel_neg_o(rx[1]),
      .rx_sel_clock_o(rx[0]));

   always #5 ref_clk_i = ~ref_clk_i;

   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction : xs

   function automatic logic al_exp(input logic [3:0] c, input logic [5:0] a);
      case (c)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: return a[c];
         4'hb, 4'hd: return a[0] | a[2] | a[3];
         4'he: return a[4] | a[5];
         4'hf: return |a;
         default: return 1'b0;
      endcase
   endfunction : al_exp

   function automatic logic [3:0] lb_exp(input logic [2:0] c, input logic t);
      case (c)
         3'h0: return 4'h0;
         3'h1: return t ? 4'h0 : 4'h8;
         3'h2: return 4'h4;
         3'h3: return 4'h2;
         3'h6: return 4'h5;
         default: return 4'h1;
      endcase
   endfunction : lb_exp

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // The expected word is noted here; the negedge monitor compares it.
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
   endtask : rd

   task automatic settle(input int k);
      repeat (k) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : settle

   task automatic wait_uc(input int lim);
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (uc !== 1'b1 && n < lim);
   endtask : wait_uc

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   always @(posedge ref_clk_i) begin
      pend <= rd_i;
      ev_last <= ev;
      ref_8k <= tog ? ~ref_8k : ref_lvl;
   end

   // Counter model follows the clear pulse, so only the clear moment comes from the design.
   always @(negedge ref_clk_i) begin
      if (pend) begin
         check(rdata & msk_q[0], exp_q[0] & msk_q[0], "read data");
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (uc === 1'b1) begin
         hold_exp = cnt_m;
         cnt_m = int'(ev_last);
      end else if (ev_last) begin
         cnt_m++;
      end
   end

   initial begin
      #500000;
      fails++;
      stop_test();
   end

   initial begin
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      pin_i <= 8'(xs());
      rd(ADDR_GLOBAL_CTRL, GLOBAL_RESET, '1);
      rd(ADDR_PIN_CTRL, PIN_RESET, '1);
      rd(ADDR_PORT_CTRL, PORT_RESET, '1);
      rd(ADDR_PIN_IN, pin_i, '1);
      rd(4'h6, 32'h0, '1);
      wr(4'h9, '1);
      rd(ADDR_GLOBAL_CTRL, 32'h0, '1);
      check(oe_n, 8'hff, "pins input after reset");
      done("reset");
      for (int c = 0; c < 16; c++) begin
         @(posedge ref_clk_i);
         alarm <= 6'(xs());
         wr(ADDR_PORT_CTRL, (32'(c) << PC_ALARM_A) | (32'(c) << PC_ALARM_B));
         wr(ADDR_PIN_CTRL, 32'h5555);
         settle(2);
         check(oe_n, 8'h0, "alarm drive");
         check(pin_o, {8{al_exp(4'(c), alarm)}}, "alarm value");
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk_i);
         alarm <= 6'h3f;
         wr(ADDR_PORT_CTRL, (32'hff << PC_ALARM_A) | (32'h1 << (k ? PC_PORT_RESET : PC_POWER_DOWN)));
         settle(2);
         check({oe_n, pin_o}, 16'h0, "held low");
      end
      for (int m = 0; m < 4; m++) begin
         if (m == 1) continue;
         wr(ADDR_PIN_CTRL, 32'({8{2'(m)}}));
         settle(2);
         check(oe_n, (m == 0) ? 8'hff : 8'h0, "mode enable");
         if (m != 0) check(pin_o, (m == 3) ? 8'hff : 8'h0, "mode level");
      end
      done("pins");
      wr(ADDR_PIN_CTRL, 32'h0);
      ref_lvl <= 1'b1;
      wr(ADDR_GLOBAL_CTRL, 32'h1 << GC_OUT8K_EN);
      settle(3);
      check({oe_n[1], pin_o[1], ref_o}, 3'b011, "8k out");
      @(posedge ref_clk_i);
      ref_lvl <= 1'b0;
      pin_i <= 8'h28;
      wr(ADDR_GLOBAL_CTRL, 32'h1 << GC_IN8K_SEL);
      settle(3);
      check({oe_n[3], ref_o}, 2'b11, "8k in");
      wr(ADDR_GLOBAL_CTRL, 32'h0);
      settle(3);
      check(ref_o, 1'b0, "8k in unselected");
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk_i);
         blk <= (i != 4);
         wr(ADDR_GLOBAL_CTRL, G_T[i]);
         wr(ADDR_PORT_CTRL, P_T[i]);
         settle(3);
         check(err, 6'b101110 >> i & 1, "error source");
      end
      done("global signals");
      for (int i = 0; i < 32; i++) begin
         @(posedge ref_clk_i);
         lin <= 10'(xs());
         wr(ADDR_PORT_CTRL, 32'(i % 8) | (32'((i / 8) % 2) << PC_LOOP_TIMED)
                            | (32'(i / 16) << PC_XCVR_EN));
         settle(3);
         check(lb, lb_exp(3'(i), i[3]), "loop decode");
         if (lb_exp(3'(i), i[3]) == 4'h8 && i < 16) check(rx, {lin[3], lin[4], lin[2]}, "dig");
         if (lb_exp(3'(i), i[3]) == 4'h8 && i > 15)
            check(rx, {lin[0], lin[1], 1'b0}, "ana");
         if (lb_exp(3'(i), i[3]) != 4'h8)
            check(rx, (i > 15) ? {lin[5], lin[6], 1'b0} : {lin[8], lin[9], lin[7]}, "rx");
      end
      done("loopback");
      wr(ADDR_PORT_CTRL, 32'h0);
      wr(ADDR_STATUS, 32'h3f);
      repeat (30) begin
         @(posedge ref_clk_i);
         ev <= 1'(xs());
      end
      @(posedge ref_clk_i);
      ev <= 1'b1;
      settle(2);
      rd(ADDR_STATUS, 32'h26, 32'h26);
      wr(ADDR_PORT_CTRL, 32'h1 << PC_UPD_BIT);
      wait_uc(8);
      check(n < 8, 1'b1, "software update");
      @(posedge ref_clk_i);
      ev <= 1'b0;
      settle(3);
      rd(ADDR_STATUS, 32'h8, 32'h8);
      wr(ADDR_PORT_CTRL, 32'h0);
      settle(2);
      rd(ADDR_STATUS, 32'h0, 32'h8);
      rd(ADDR_HOLD, hold_exp, '1);
      wr(ADDR_GLOBAL_CTRL, 32'h1 << GC_UPD_BIT);
      wr(ADDR_PORT_CTRL, 32'h1 << PC_UPD_BIT);
      settle(4);
      rd(ADDR_STATUS, 32'h8, 32'h18);
      wr(ADDR_PORT_CTRL, 32'h1 << PC_USE_GLOBAL);
      settle(4);
      rd(ADDR_STATUS, 32'h10, 32'h10);
      wr(ADDR_GLOBAL_CTRL, 32'h1);
      settle(3);
      rd(ADDR_HOLD, hold_exp, '1);
      pin_i <= 8'h80;
      wait_uc(6);
      check(n < 6, 1'b1, "pin update");
      settle(3);
      rd(ADDR_STATUS, 32'h8, 32'h8);
      pin_i <= 8'h0;
      settle(2);
      rd(ADDR_STATUS, 32'h0, 32'h8);
      done("monitor update");
      wr(ADDR_STATUS, 32'h3f);
      wr(ADDR_GLOBAL_CTRL, 32'h2);
      tog <= 1'b1;
      wait_uc(17000);
      check(n < 17000, 1'b1, "first second");
      wait_uc(17000);
      check(n, 2 * REF_DIVIDE, "second period");
      rd(ADDR_STATUS, 32'h1, 32'h1);
      check(irq, 1'b0, "masked irq");
      wr(ADDR_GLOBAL_CTRL, 32'h2 | (32'h1 << GC_IRQ_EN));
      settle(2);
      check(irq, 1'b1, "irq enabled");
      wr(ADDR_STATUS, 32'h1);
      settle(2);
      check(irq, 1'b0, "irq cleared");
      done("one second");
      stop_test();
   end
endmodule : gsl_top_tb
`default_nettype wire
